// ### hw/mtf_client.sv
// modbus/tcp query client for discrete inputs and coils of a device server
// assumes: tx/rx byte streams run on this clock; one query in flight
`timescale 1ns/1ps
`default_nettype none
module mtf_client #(
  parameter int MAX_POINTS = 16,
  parameter int RSP_TIMEOUT = mtf_pkg::RSP_TIMEOUT_CYC
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic [7:0] cmdStation,
  input wire logic [7:0] cmdFunction,
  input wire logic [15:0] cmdRef,
  input wire logic [15:0] cmdCount,
  input wire logic [MAX_POINTS-1:0] cmdCoils,
  output logic txValid,
  input wire logic txReady,
  output logic [7:0] txData,
  output logic txLast,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  output logic rspValid,
  output logic [2:0] rspStatus,
  output logic [7:0] rspFunction,
  output logic [7:0] rspExcCode,
  output logic [MAX_POINTS-1:0] rspBits,
  output logic [31:0] rspWord32,
  output logic busy
);

  localparam int NB = (MAX_POINTS + 7) / 8;
  localparam int MAXB = mtf_pkg::QP_DATA + NB;
  localparam int MAXR = mtf_pkg::RP_DATA + 3 + NB;

  typedef struct packed {
    mtf_pkg::mtf_state_t state;
    logic [15:0] tid;
    logic [15:0] curTid;
    logic [7:0] station;
    logic [7:0] fc;
    logic [15:0] refNum;
    logic [15:0] count;
    logic [31:0] timer;
    mtf_pkg::mtf_status_t status;
    logic [7:0] rspFc;
    logic [7:0] exc;
    logic [MAX_POINTS-1:0] bits;
    logic [31:0] word32;
  } mtf_cls_t;

  mtf_cls_t q;
  mtf_cls_t d;

  logic loadValid;
  logic loadReady;
  logic [7:0] loadLen;
  logic [MAXB-1:0][7:0] qry;
  logic [7:0] qryLen;
  logic [7:0] dataCnt;
  logic [15:0] coilWord;
  logic [NB*8-1:0] coilsPad;
  logic cmdOk;
  logic isRead;
  logic frameDone;
  logic frameBad;
  logic [7:0] frameLen;
  logic [15:0] frameTid;
  logic [MAXR-1:0][7:0] fb;
  logic ours;
  logic isExc;
  logic isNormal;
  logic readOk;
  logic writeOk;
  logic [MAX_POINTS-1:0] unpacked;

  // ****************************************
  // command check
  // ****************************************
  assign isRead = (cmdFunction == mtf_pkg::FC_RD_COILS) ||
                  (cmdFunction == mtf_pkg::FC_RD_INPUTS);
  // only the four served codes go out; except for a single-coil write, a count of zero
  // or beyond the point width is refused before anything reaches the link
  always_comb begin
    cmdOk = (cmdStation <= mtf_pkg::MAX_STATION);
    if (cmdFunction == mtf_pkg::FC_NONE) cmdOk = 1'b0;
    if (!isRead && cmdFunction != mtf_pkg::FC_WR_COIL &&
        cmdFunction != mtf_pkg::FC_WR_COILS) cmdOk = 1'b0;
    if (cmdFunction != mtf_pkg::FC_WR_COIL &&
        (cmdCount == 16'h0000 || cmdCount > 16'(MAX_POINTS))) begin
      cmdOk = 1'b0;
    end
  end

  // ****************************************
  // query builder
  // ****************************************
  always_comb begin
    coilsPad = '0;
    for (int j = 0; j < MAX_POINTS; j++) begin
      coilsPad[j] = cmdCoils[j] && (16'(j) < cmdCount);
    end
  end

  assign coilWord = cmdCoils[0] ? mtf_pkg::COIL_ON : mtf_pkg::COIL_OFF;
  assign dataCnt = mtf_pkg::mtf_byte_count(cmdCount);

  always_comb begin
    qry = '0;
    qryLen = mtf_pkg::QRY_FIXED_LEN;
    qry[mtf_pkg::QP_TID] = mtf_pkg::mtf_hi(q.tid);
    qry[mtf_pkg::QP_TID+1] = mtf_pkg::mtf_lo(q.tid);
    qry[mtf_pkg::QP_PROTO] = mtf_pkg::PROTO_ID;
    qry[mtf_pkg::QP_PROTO+1] = mtf_pkg::PROTO_ID;
    qry[mtf_pkg::QP_LEN_HI] = mtf_pkg::LEN_HI;
    // station goes out as given: the far end serves or forwards it
    qry[mtf_pkg::QP_STATION] = cmdStation;
    qry[mtf_pkg::QP_FC] = cmdFunction;
    qry[mtf_pkg::QP_REF] = mtf_pkg::mtf_hi(cmdRef);
    qry[mtf_pkg::QP_REF+1] = mtf_pkg::mtf_lo(cmdRef);
    qry[mtf_pkg::QP_CNT] = mtf_pkg::mtf_hi(cmdCount);
    qry[mtf_pkg::QP_CNT+1] = mtf_pkg::mtf_lo(cmdCount);
    if (cmdFunction == mtf_pkg::FC_WR_COIL) begin
      qry[mtf_pkg::QP_CNT] = mtf_pkg::mtf_hi(coilWord);
      qry[mtf_pkg::QP_CNT+1] = mtf_pkg::mtf_lo(coilWord);
    end
    if (cmdFunction == mtf_pkg::FC_WR_COILS) begin
      qry[mtf_pkg::QP_BCNT] = dataCnt;
      for (int i = 0; i < NB; i++) begin
        qry[mtf_pkg::QP_DATA+i] = coilsPad[i*8 +: 8];
      end
      qryLen = mtf_pkg::QRY_FIXED_LEN + 8'h01 + dataCnt;
    end
    qry[mtf_pkg::QP_LEN_LO] = qryLen;
  end

  assign loadValid = (q.state == mtf_pkg::ST_IDLE) && cmdValid && cmdOk;
  assign loadLen = 8'(mtf_pkg::HDR_LEN) + qryLen;

  mtf_frame_tx #(
    .MAXB(MAXB)
  ) u_tx (
    .clock(clock),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .loadValid(loadValid),
    .loadReady(loadReady),
    .loadLen(loadLen),
    .loadBytes(qry),
    .txValid(txValid),
    .txReady(txReady),
    .txData(txData),
    .txLast(txLast)
  );

  mtf_frame_rx #(
    .MAXR(MAXR)
  ) u_rx (
    .clock(clock),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .rxValid(rxValid),
    .rxData(rxData),
    .frameDone(frameDone),
    .frameBad(frameBad),
    .frameLen(frameLen),
    .frameTid(frameTid),
    .frameBytes(fb)
  );

  // ****************************************
  // reply check
  // ****************************************
  // a frame that is not for the query in flight is dropped silently
  assign ours = frameDone && (frameTid == q.curTid) &&
                (fb[0] == q.station);
  assign isExc = (fb[mtf_pkg::RP_FC] == (q.fc | mtf_pkg::FC_EXC_FLAG));
  assign isNormal = (fb[mtf_pkg::RP_FC] == q.fc);
  assign readOk = (fb[mtf_pkg::RP_BCNT] ==
                   mtf_pkg::mtf_byte_count(q.count)) &&
                  (frameLen == 8'h03 + fb[mtf_pkg::RP_BCNT]);
  assign writeOk = (frameLen == mtf_pkg::WR_ECHO_LEN) &&
                   (fb[mtf_pkg::RP_REF] == mtf_pkg::mtf_hi(q.refNum)) &&
                   (fb[mtf_pkg::RP_REF+1] == mtf_pkg::mtf_lo(q.refNum));

  always_comb begin
    unpacked = '0;
    for (int j = 0; j < MAX_POINTS; j++) begin
      unpacked[j] = (16'(j) < q.count) &&
                    fb[mtf_pkg::RP_DATA + j/8][j%8];
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    d = q;
    case (q.state)
      mtf_pkg::ST_IDLE: begin
        if (cmdValid) begin
          d.station = cmdStation;
          d.fc = cmdFunction;
          d.refNum = cmdRef;
          d.count = cmdCount;
          d.rspFc = cmdFunction;
          d.exc = 8'h00;
          d.bits = '0;
          d.word32 = 32'h0000_0000;
          if (cmdOk) begin
            d.curTid = q.tid;
            d.tid = q.tid + 16'h0001;
            d.state = mtf_pkg::ST_SEND;
          end else begin
            d.status = mtf_pkg::RS_BAD_CMD;
            d.state = mtf_pkg::ST_DONE;
          end
        end
      end
      mtf_pkg::ST_SEND: begin
        if (loadReady) begin
          d.timer = 32'h0000_0000;
          if (q.station == mtf_pkg::BCAST_STATION) begin
            d.status = mtf_pkg::RS_NO_REPLY;
            d.state = mtf_pkg::ST_DONE;
          end else begin
            d.state = mtf_pkg::ST_WAIT;
          end
        end
      end
      mtf_pkg::ST_WAIT: begin
        d.timer = q.timer + 32'h0000_0001;
        if (ours) begin
          d.state = mtf_pkg::ST_DONE;
          d.rspFc = fb[mtf_pkg::RP_FC];
          d.status = mtf_pkg::RS_BAD_FRAME;
          if (frameBad) begin
            d.status = mtf_pkg::RS_BAD_FRAME;
          end else if (isExc && frameLen == mtf_pkg::EXC_LEN) begin
            d.status = mtf_pkg::RS_EXCEPTION;
            d.exc = fb[mtf_pkg::RP_EXC];
          end else if (isNormal && (q.fc == mtf_pkg::FC_RD_COILS ||
                       q.fc == mtf_pkg::FC_RD_INPUTS) && readOk) begin
            d.status = mtf_pkg::RS_OK;
            d.bits = unpacked;
            d.word32 = mtf_pkg::mtf_get32(fb[mtf_pkg::RP_DATA],
                                          fb[mtf_pkg::RP_DATA+1],
                                          fb[mtf_pkg::RP_DATA+2],
                                          fb[mtf_pkg::RP_DATA+3]);
          end else if (isNormal && writeOk) begin
            d.status = mtf_pkg::RS_OK;
          end
        end else if (q.timer == 32'(RSP_TIMEOUT - 1)) begin
          // a lost reply must not hang the client forever
          d.status = mtf_pkg::RS_TIMEOUT;
          d.state = mtf_pkg::ST_DONE;
        end
      end
      mtf_pkg::ST_DONE: begin
        d.state = mtf_pkg::ST_IDLE;
      end
      default: begin
        d.state = mtf_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      q <= '0;
    end else if (clkEn) begin
      q <= d;
    end
  end

  assign cmdReady = (q.state == mtf_pkg::ST_IDLE);
  assign rspValid = (q.state == mtf_pkg::ST_DONE);
  assign rspStatus = q.status;
  assign rspFunction = q.rspFc;
  assign rspExcCode = q.exc;
  assign rspBits = q.bits;
  assign rspWord32 = q.word32;
  assign busy = (q.state != mtf_pkg::ST_IDLE);

  // ****************************************
  // checks
  // ****************************************
  chk_tx_only_query: assert property (@(posedge clock)
    disable iff (sys_rst)
    txValid |-> q.state == mtf_pkg::ST_SEND)
    else $error("link byte sent outside a query");

  chk_bcast_silent: assert property (@(posedge clock)
    disable iff (sys_rst || !clkEn)
    q.state == mtf_pkg::ST_SEND && loadReady &&
    q.station == mtf_pkg::BCAST_STATION
    |=> rspValid && rspStatus == mtf_pkg::RS_NO_REPLY)
    else $error("broadcast did not finish without reply");

  chk_station_range: assert property (@(posedge clock)
    disable iff (sys_rst || !clkEn)
    cmdReady && cmdValid && cmdStation > mtf_pkg::MAX_STATION
    |=> rspValid && rspStatus == mtf_pkg::RS_BAD_CMD ##1 !busy)
    else $error("station above range was not refused");

  chk_fc_zero: assert property (@(posedge clock)
    disable iff (sys_rst || !clkEn)
    cmdReady && cmdValid && cmdFunction == mtf_pkg::FC_NONE
    |-> !loadValid)
    else $error("function code zero was sent");

  chk_tid_fresh: assert property (@(posedge clock)
    disable iff (sys_rst || !clkEn)
    loadValid |=> q.curTid == $past(q.tid) &&
                  q.tid == $past(q.tid) + 16'h0001)
    else $error("transaction identifier not advanced");

  chk_hdr_zero: assert property (@(posedge clock)
    disable iff (sys_rst)
    loadValid |-> qry[mtf_pkg::QP_PROTO] == 8'h00 &&
                  qry[mtf_pkg::QP_PROTO+1] == 8'h00 &&
                  qry[mtf_pkg::QP_LEN_HI] == 8'h00)
    else $error("header zero field not zero");

  chk_len_match: assert property (@(posedge clock)
    disable iff (sys_rst)
    loadValid |-> loadLen == qry[mtf_pkg::QP_LEN_LO] + 8'h06 &&
      qry[mtf_pkg::QP_LEN_LO] == ((cmdFunction == mtf_pkg::FC_WR_COILS) ?
      8'h07 + mtf_pkg::mtf_byte_count(cmdCount) : 8'h06))
    else $error("length byte disagrees with frame size");

  chk_exc_flag: assert property (@(posedge clock)
    disable iff (sys_rst || !clkEn)
    q.state == mtf_pkg::ST_WAIT && ours && !frameBad && isExc &&
    frameLen == mtf_pkg::EXC_LEN
    |=> rspValid && rspStatus == mtf_pkg::RS_EXCEPTION &&
        rspFunction[7])
    else $error("flagged reply not reported as exception");

endmodule : mtf_client
`default_nettype wire

// ### hw/mtf_frame_rx.sv
// reply collector: checks the six-byte header and gathers station bytes
// assumes: rx bytes come from logic on the same clock, no back-pressure
`timescale 1ns/1ps
`default_nettype none
module mtf_frame_rx #(
  parameter int MAXR = 8
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  output logic frameDone,
  output logic frameBad,
  output logic [7:0] frameLen,
  output logic [15:0] frameTid,
  output logic [MAXR-1:0][7:0] frameBytes
);

  typedef struct packed {
    logic [8:0] pos;
    logic [7:0] len;
    logic [15:0] tid;
    logic bad;
    logic done;
    logic [MAXR-1:0][7:0] bytes;
  } mtf_rxs_t;

  mtf_rxs_t q;
  mtf_rxs_t d;
  logic [8:0] slot;

  assign slot = q.pos - mtf_pkg::HP_PAYLOAD;

  // ****************************************
  // parser
  // ****************************************
  always_comb begin
    d = q;
    d.done = 1'b0;
    if (rxValid) begin
      d.pos = q.pos + 9'h001;
      if (q.pos == mtf_pkg::HP_TID_HI) begin
        d.bad = 1'b0;
        d.bytes = '0;
        d.tid[15:8] = rxData;
      end else if (q.pos == mtf_pkg::HP_TID_LO) begin
        d.tid[7:0] = rxData;
      end else if (q.pos == mtf_pkg::HP_PROTO_HI ||
                   q.pos == mtf_pkg::HP_PROTO_LO) begin
        if (rxData != mtf_pkg::PROTO_ID) d.bad = 1'b1;
      end else if (q.pos == mtf_pkg::HP_LEN_HI) begin
        if (rxData != mtf_pkg::LEN_HI) d.bad = 1'b1;
      end else if (q.pos == mtf_pkg::HP_LEN_LO) begin
        d.len = rxData;
        // a frame must carry at least its station byte
        if (rxData == 8'h00) begin
          d.bad = 1'b1;
          d.done = 1'b1;
          d.pos = '0;
        end
      end else begin
        // payload starts right after the header; an empty data field is
        // fine, the length alone closes the frame
        if (slot < 9'(MAXR)) begin
          d.bytes[slot] = rxData;
        end else begin
          d.bad = 1'b1;
        end
        if (q.pos == 9'(q.len) + 9'h005) begin
          d.done = 1'b1;
          d.pos = '0;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      q <= '0;
    end else if (clkEn) begin
      q <= d;
    end
  end

  assign frameDone = q.done;
  assign frameBad = q.bad;
  assign frameLen = q.len;
  assign frameTid = q.tid;
  assign frameBytes = q.bytes;

  chk_rx_done_pulse: assert property (@(posedge clock)
    disable iff (sys_rst || !clkEn)
    frameDone |-> q.pos == 9'h000)
    else $error("frame closed without returning to header");

endmodule : mtf_frame_rx
`default_nettype wire

// ### hw/mtf_frame_tx.sv
// query serialiser: loads a whole frame, then streams it byte by byte
// assumes: the loader holds loadValid data only for the accepting cycle
`timescale 1ns/1ps
`default_nettype none
module mtf_frame_tx #(
  parameter int MAXB = 15
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic loadValid,
  output logic loadReady,
  input wire logic [7:0] loadLen,
  input wire logic [MAXB-1:0][7:0] loadBytes,
  output logic txValid,
  input wire logic txReady,
  output logic [7:0] txData,
  output logic txLast
);

  typedef struct packed {
    logic busy;
    logic [7:0] left;
    logic [MAXB-1:0][7:0] bytes;
  } mtf_txs_t;

  mtf_txs_t q;
  mtf_txs_t d;

  // ****************************************
  // shifter
  // ****************************************
  // a shift register keeps txData straight off a flop, no wide mux
  always_comb begin
    d = q;
    if (q.busy && txReady) begin
      d.bytes = q.bytes >> 8;
      d.left = q.left - 8'h01;
      d.busy = (q.left != 8'h01);
    end else if (!q.busy && loadValid) begin
      d.busy = (loadLen != 8'h00);
      d.left = loadLen;
      d.bytes = loadBytes;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      q <= '0;
    end else if (clkEn) begin
      q <= d;
    end
  end

  assign loadReady = !q.busy;
  assign txValid = q.busy;
  assign txData = q.bytes[0];
  assign txLast = q.busy && (q.left == 8'h01);

  chk_tx_stall_hold: assert property (@(posedge clock)
    disable iff (sys_rst || !clkEn)
    txValid && !txReady |=> txValid && $stable(txData))
    else $error("tx byte changed while stalled");

endmodule : mtf_frame_tx
`default_nettype wire

// ### hw/mtf_pkg.sv
// constants, types and helpers shared by the modbus/tcp query client
// assumes: one 100 MHz clock, byte-wide frame streams on both link sides
package mtf_pkg;

  // ****************************************
  // frame layout
  // ****************************************
  localparam int HDR_LEN = 6;
  localparam int QP_TID = 0;
  localparam int QP_PROTO = 2;
  localparam int QP_LEN_HI = 4;
  localparam int QP_LEN_LO = 5;
  localparam int QP_STATION = 6;
  localparam int QP_FC = 7;
  localparam int QP_REF = 8;
  localparam int QP_CNT = 10;
  localparam int QP_BCNT = 12;
  localparam int QP_DATA = 13;
  // positions inside the received station payload (station byte is 0)
  localparam int RP_FC = 1;
  localparam int RP_BCNT = 2;
  localparam int RP_EXC = 2;
  localparam int RP_DATA = 3;
  localparam int RP_REF = 2;
  localparam logic [8:0] HP_TID_HI = 9'h000;
  localparam logic [8:0] HP_TID_LO = 9'h001;
  localparam logic [8:0] HP_PROTO_HI = 9'h002;
  localparam logic [8:0] HP_PROTO_LO = 9'h003;
  localparam logic [8:0] HP_LEN_HI = 9'h004;
  localparam logic [8:0] HP_LEN_LO = 9'h005;
  localparam logic [8:0] HP_PAYLOAD = 9'h006;

  // ****************************************
  // field values
  // ****************************************
  localparam logic [7:0] PROTO_ID = 8'h00;
  localparam logic [7:0] LEN_HI = 8'h00;
  localparam logic [7:0] MAX_STATION = 8'hF7;
  localparam logic [7:0] BCAST_STATION = 8'h00;
  localparam logic [7:0] FC_NONE = 8'h00;
  localparam logic [7:0] FC_RD_COILS = 8'h01;
  localparam logic [7:0] FC_RD_INPUTS = 8'h02;
  localparam logic [7:0] FC_WR_COIL = 8'h05;
  localparam logic [7:0] FC_WR_COILS = 8'h0F;
  localparam logic [7:0] FC_EXC_FLAG = 8'h80;
  localparam logic [7:0] QRY_FIXED_LEN = 8'h06;
  localparam logic [7:0] EXC_LEN = 8'h03;
  localparam logic [7:0] WR_ECHO_LEN = 8'h06;
  localparam logic [15:0] COIL_ON = 16'hFF00;
  localparam logic [15:0] COIL_OFF = 16'h0000;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int RSP_TIMEOUT_NS = 1000000;
  localparam int RSP_TIMEOUT_CYC = RSP_TIMEOUT_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_WAIT = 2'b11,
    ST_DONE = 2'b10
  } mtf_state_t;

  typedef enum logic [2:0] {
    RS_OK = 3'h0,
    RS_EXCEPTION = 3'h1,
    RS_BAD_CMD = 3'h2,
    RS_BAD_FRAME = 3'h3,
    RS_TIMEOUT = 3'h4,
    RS_NO_REPLY = 3'h5
  } mtf_status_t;

  function automatic logic [7:0] mtf_hi(input logic [15:0] v);
    return v[15:8];
  endfunction : mtf_hi

  function automatic logic [7:0] mtf_lo(input logic [15:0] v);
    return v[7:0];
  endfunction : mtf_lo

  function automatic logic [7:0] mtf_byte_count(input logic [15:0] pts);
    logic [16:0] s;
    s = {1'b0, pts} + 17'h00007;
    return s[10:3];
  endfunction : mtf_byte_count

  // bytes arrive low word first, each word high byte first
  function automatic logic [31:0] mtf_get32(input logic [7:0] b0,
                                            input logic [7:0] b1,
                                            input logic [7:0] b2,
                                            input logic [7:0] b3);
    return {b2, b3, b0, b1};
  endfunction : mtf_get32

endpackage : mtf_pkg

// ### tb/mtf_dev_model.sv
// device-server model: coils and discrete inputs behind the query link
// assumes: byte streams on the client clock, one query at a time
`timescale 1ns/1ps
`default_nettype none
module mtf_dev_model #(
  parameter logic [7:0] OWN_ID = 8'h01
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic slow,
  input wire logic txValid,
  output logic txReady,
  input wire logic [7:0] txData,
  input wire logic txLast,
  output logic rxValid,
  output logic [7:0] rxData,
  input wire logic [15:0] din,
  output logic [15:0] coilOut
);
  logic [7:0] q [0:31];
  logic [7:0] r [0:15];
  int n, rn, k;
  logic gap;

  initial {txReady, rxValid, rxData} = 10'h000;

  task automatic serve();
    logic [15:0] rf, ct, src;
    logic [7:0] fc, ln;
    rf = {q[8], q[9]};
    ct = {q[10], q[11]};
    fc = q[7];
    src = (fc == 8'h01) ? coilOut : din;
    ln = 8'h06;
    for (int i = 0; i < 12; i++) r[i] = q[i];
    // no serial slave attached: foreign stations are dropped
    if (q[6] != OWN_ID && q[6] != 8'h00) return;
    if (!(fc inside {8'h01, 8'h02, 8'h05, 8'h0F}) || rf > 16'h000F ||
        (fc != 8'h05 && rf + ct > 16'h0010)) begin
      r[7] = fc | 8'h80;
      r[8] = 8'h02;
      ln = 8'h03;
    end else if (fc == 8'h05) begin
      coilOut[rf[3:0]] = (ct == 16'hFF00);
    end else if (fc == 8'h0F) begin
      for (int i = 0; i < ct; i++) coilOut[rf + i] = q[13 + i / 8][i % 8];
    end else begin
      r[8] = 8'((ct + 16'h0007) >> 3);
      {r[10], r[9]} = (src >> rf) & ((16'h0001 << ct) - 16'h0001);
      ln = 8'h03 + r[8];
    end
    r[4] = 8'h00;
    r[5] = ln;
    k = 0;
    rn = (q[6] == 8'h00) ? 0 : 6 + int'(ln);
  endtask : serve

  always @(posedge clock) begin
    if (sys_rst) begin
      txReady <= 1'b0;
      rxValid <= 1'b0;
      rxData <= 8'h00;
      coilOut = 16'h0000;
      n = 0;
      rn = 0;
      k = 0;
      gap = 1'b0;
    end else begin
      txReady <= slow ? ~txReady : 1'b1;
      gap = slow & ~gap;
      rxValid <= k < rn && !gap;
      // idle line toggles so a stale byte never looks like data
      rxData <= (k < rn && !gap) ? r[k] : ~rxData;
      if (k < rn && !gap) k = k + 1;
      if (txValid && txReady) begin
        q[n] = txData;
        n = n + 1;
        if (txLast) begin
          serve();
          n = 0;
        end
      end
    end
  end
endmodule : mtf_dev_model
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench: query client against the device-server model
// assumes: the model serves station 01 and drops other unicasts
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin \
  num_errors++; $display("[ERR] %s expected %0h seen %0h", nm, ex, gt); \
  end end
module tb_top;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic cmdValid = 1'b0;
  logic slow = 1'b0;
  logic clkEn = 1'b1;
  logic [7:0] cmdStation = 8'h00, cmdFunction = 8'h00;
  logic [15:0] cmdRef = 16'h0000, cmdCount = 16'h0000, cmdCoils = 16'h0000;
  logic [15:0] din = 16'h0000, tid = 16'h0000, coilOut, rspBits;
  logic cmdReady, txValid, txReady, txLast, rxValid, rspValid, busy;
  logic [7:0] txData, rxData, rspFunction, rspExcCode;
  logic [2:0] rspStatus;
  logic [31:0] rspWord32;
  logic [7:0] frm [0:31];
  int nf = 0;
  int num_errors = 0;
  int compares = 0;

  always #5 clock = ~clock;

  mtf_client #(.MAX_POINTS(16), .RSP_TIMEOUT(50)) i_mtf_client (
    .clock(clock), .sys_rst(sys_rst), .clkEn(clkEn), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdStation(cmdStation), .cmdFunction(cmdFunction),
    .cmdRef(cmdRef), .cmdCount(cmdCount), .cmdCoils(cmdCoils),
    .txValid(txValid), .txReady(txReady), .txData(txData), .txLast(txLast),
    .rxValid(rxValid), .rxData(rxData), .rspValid(rspValid),
    .rspStatus(rspStatus), .rspFunction(rspFunction),
    .rspExcCode(rspExcCode), .rspBits(rspBits), .rspWord32(rspWord32),
    .busy(busy));
  mtf_dev_model i_mtf_dev_model (.clock(clock), .sys_rst(sys_rst),
    .slow(slow), .txValid(txValid), .txReady(txReady), .txData(txData),
    .txLast(txLast), .rxValid(rxValid), .rxData(rxData), .din(din),
    .coilOut(coilOut));

  always @(posedge clock) if (txValid && txReady) begin
    frm[nf] = txData;
    nf = nf + 1;
  end

  // ****************************************
  // query driver and frame judge
  // ****************************************
  task automatic run(input logic [7:0] st, fc, input logic [15:0] rf, ct,
                     input logic [15:0] cl, input logic [2:0] ex);
    logic [15:0] ec;
    ec = (fc != 8'h05) ? ct : (cl[0] ? 16'hFF00 : 16'h0000);
    @(posedge clock);
    {cmdStation, cmdFunction, cmdRef, cmdCount, cmdCoils} <= {st, fc, rf,
      ct, cl};
    cmdValid <= 1'b1;
    nf = 0;
    do @(negedge clock); while (cmdReady !== 1'b1);
    @(posedge clock);
    cmdValid <= 1'b0;
    do @(negedge clock); while (rspValid !== 1'b1);
    `CHK("status", ex, rspStatus)
    if (ex == mtf_pkg::RS_BAD_CMD) `CHK("sent", 0, nf)
    else begin
      `CHK("tid", tid, {frm[0], frm[1]})
      `CHK("hdr", 24'h000000, {frm[2], frm[3], frm[4]})
      `CHK("len", 8'(nf - 6), frm[5])
      `CHK("addr", {st, fc, rf}, {frm[6], frm[7], frm[8], frm[9]})
      `CHK("cnt", ec, {frm[10], frm[11]})
      if (fc == 8'h0F) `CHK("bcnt", 8'((ct + 16'h0007) >> 3), frm[12])
      tid = tid + 16'h0001;
    end
  endtask : run

  task automatic t_bits();
    run(8'h01, 8'h0F, 16'h0000, 16'h000A, 16'h02A5, mtf_pkg::RS_OK);
    `CHK("fc", 8'h0F, rspFunction)
    `CHK("coils", 16'h02A5, coilOut)
    slow <= 1'b1;
    run(8'h01, 8'h01, 16'h0000, 16'h000A, 16'h0000, mtf_pkg::RS_OK);
    `CHK("coils", 16'h02A5, rspBits)
    `CHK("fc", 8'h01, rspFunction)
    run(8'h01, 8'h01, 16'h0003, 16'h0007, 16'h0000, mtf_pkg::RS_OK);
    `CHK("coils", 16'h0054, rspBits)
    slow <= 1'b0;
    din <= 16'hC33B;
    run(8'h01, 8'h02, 16'h0000, 16'h0010, 16'h0000, mtf_pkg::RS_OK);
    `CHK("inputs", 16'hC33B, rspBits)
    `CHK("word32", 32'h00003BC3, rspWord32)
    run(8'h01, 8'h02, 16'h0004, 16'h0005, 16'h0000, mtf_pkg::RS_OK);
    `CHK("inputs", 16'h0013, rspBits)
    run(8'h01, 8'h05, 16'h0004, 16'h0000, 16'h0001, mtf_pkg::RS_OK);
    `CHK("coils", 16'h02B5, coilOut)
    run(8'h01, 8'h05, 16'h0000, 16'h0000, 16'h0000, mtf_pkg::RS_OK);
    `CHK("coils", 16'h02B4, coilOut)
    $display("done read and write bits");
  endtask : t_bits

  task automatic t_faults();
    logic [31:0] tbl [0:4];
    tbl = '{32'hF8010001, 32'h01000001, 32'h01030001, 32'h01010000,
      32'h01020011};
    for (int i = 1; i <= 2; i++) begin
      run(8'h01, 8'(i), 16'h000A, 16'h000A, 16'h0000,
        mtf_pkg::RS_EXCEPTION);
      `CHK("fc", 8'(i) | 8'h80, rspFunction)
      `CHK("code", 8'h02, rspExcCode)
    end
    foreach (tbl[i]) run(tbl[i][31:24], tbl[i][23:16], 16'h0000,
      tbl[i][15:0], 16'h0000, mtf_pkg::RS_BAD_CMD);
    run(8'h00, 8'h0F, 16'h0000, 16'h0010, 16'h5A5A, mtf_pkg::RS_NO_REPLY);
    `CHK("bcast", 16'h5A5A, coilOut)
    run(8'h09, 8'h02, 16'h0000, 16'h0001, 16'h0000, mtf_pkg::RS_TIMEOUT);
    $display("done faults, broadcast and timeout");
  endtask : t_faults

  // a held command must not be taken while the clock enable is low
  task automatic t_freeze();
    @(posedge clock);
    clkEn <= 1'b0;
    {cmdStation, cmdFunction, cmdCount} <= {8'h01, 8'h02, 16'h0001};
    cmdValid <= 1'b1;
    repeat (3) @(posedge clock);
    @(negedge clock);
    `CHK("frozen", 1'b0, busy)
    `CHK("ready", 1'b1, cmdReady)
    @(posedge clock);
    cmdValid <= 1'b0;
    clkEn <= 1'b1;
    $display("done clock enable freeze");
  endtask : t_freeze

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    t_bits();
    t_faults();
    t_freeze();
    print_verdict();
  end

  initial begin
    #100000;
    num_errors++;
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
